// file: dv/aac_conv_model.sv
`timescale 1ns/1ps
module aac_conv_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Control side
	input wire logic conv_start,
	input wire logic [2:0] mux_chan,
	input wire logic [2:0] gain_code,
	// Result side
	output logic conv_done,
	output logic [11:0] conv_data
);
	logic [4:0] busy_cnt;
	// Data only valid with done; otherwise it toggles so a stale sample shows up
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_cnt <= 5'h00;
			conv_done <= 1'b0;
			conv_data <= 12'hA5A;
		end else begin
			conv_done <= (busy_cnt == 5'h01);
			conv_data <= (busy_cnt == 5'h01) ? {mux_chan, gain_code, 6'h15} : ~conv_data;
			if (conv_start) begin
				busy_cnt <= 5'h0C;
			end else if (busy_cnt != 5'h00) begin
				busy_cnt <= busy_cnt - 5'h01;
			end
		end
	end
endmodule : aac_conv_model

// file: dv/aac_ctrl_tb_top.sv
`timescale 1ns/1ps
module aac_ctrl_tb_top;
	logic mclk, reset_n, wr, rd, ext_trig, conv_start, conv_done, bipolar, irq, clk_en;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, d;
	logic [2:0] mux_chan, gain_code;
	logic [11:0] conv_data;
	int fails, cmp_count, cyc, n_start, last_start, gap, n0;
	logic [17:0] rows [10] = '{{4'h8, 8'h03, 3'h3, 3'h0}, {4'h8, 8'h07, 3'h7, 3'h0}, {4'h8, 8'h00, 3'h0, 3'h0},
		{4'h9, 8'h01, 3'h0, 3'h1}, {4'h9, 8'h02, 3'h0, 3'h2}, {4'h9, 8'h04, 3'h0, 3'h4}, {4'h9, 8'h05, 3'h0, 3'h4},
		{4'h8, 8'h05, 3'h5, 3'h4}, {4'h9, 8'h03, 3'h5, 3'h3}, {4'hE, 8'h09, 3'h5, 3'h3}};
	aac_ctrl i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ext_trig(ext_trig), .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
		.mux_chan(mux_chan), .gain_code(gain_code), .bipolar(bipolar), .irq(irq));
	aac_conv_model i_conv (.mclk(mclk), .reset_n(reset_n), .conv_start(conv_start), .mux_chan(mux_chan),
		.gain_code(gain_code), .conv_done(conv_done), .conv_data(conv_data));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Cycle count, start count and the gap between the last two starts
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (conv_start === 1'b1) begin
			n_start <= n_start + 1;
			gap <= cyc - last_start;
			last_start <= cyc;
		end
		if (cyc >= 20000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			fails = fails + 1;
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	task automatic conv_once();
		n0 = n_start;
		wr_reg(aac_pkg::ADDR_SOFT_TRIG, 8'h00);
		settle(30);
		chk(16'(n_start - n0), 16'h0001);
	endtask : conv_once
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		{fails, cmp_count, cyc, n_start, last_start, gap} = '0;
		{reset_n, wr, rd, ext_trig, addr, wdata} = '0;
		clk_en = 1'b1;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		settle(1);
		chk(mux_chan, 16'h0000);
		chk({gain_code, bipolar}, 16'h0001);
		chk(irq, 16'h0000);
		rd_reg(aac_pkg::ADDR_MODE);
		chk(d, 16'h0000);
		wr_reg(aac_pkg::ADDR_MODE, 8'h07);
		rd_reg(aac_pkg::ADDR_MODE);
		chk(d, 16'h0000);
		rd_reg(aac_pkg::ADDR_IRQ_STAT);
		chk(d, 16'h0080);
		$display("test reset done");
		foreach (rows[i]) begin
			wr_reg(rows[i][17:14], rows[i][13:6]);
			settle(1);
			chk({mux_chan, gain_code}, 16'(rows[i][5:0]));
		end
		rd_reg(4'hE);
		chk(d, 16'h0000);
		$display("test table done");
		// A write while the clock enable is low must leave the channel alone
		@(posedge mclk);
		clk_en <= 1'b0;
		wr_reg(aac_pkg::ADDR_CHAN, 8'h02);
		settle(2);
		chk(mux_chan, 16'h0005);
		@(posedge mclk);
		clk_en <= 1'b1;
		$display("test freeze done");
		wr_reg(aac_pkg::ADDR_IRQ_MASK, 8'h01);
		conv_once();
		chk(irq, 16'h0000);
		rd_reg(aac_pkg::ADDR_RES_LO);
		chk(d, 16'h00D5);
		rd_reg(aac_pkg::ADDR_RES_HI);
		chk(d, 16'h000A);
		$display("test polled done");
		wr_reg(aac_pkg::ADDR_MODE, 8'h01);
		rd_reg(aac_pkg::ADDR_STATUS);
		conv_once();
		chk(irq, 16'h0001);
		rd_reg(aac_pkg::ADDR_IRQ_STAT);
		chk(d, 16'h0001);
		rd_reg(aac_pkg::ADDR_STATUS);
		chk(d[0], 16'h0001);
		settle(2);
		chk(irq, 16'h0000);
		conv_once();
		rd_reg(aac_pkg::ADDR_STATUS);
		chk(d[0], 16'h0000);
		wr_reg(aac_pkg::ADDR_IRQ_CLR, 8'h00);
		conv_once();
		chk(irq, 16'h0001);
		$display("test interrupt done");
		rd_reg(aac_pkg::ADDR_STATUS);
		wr_reg(aac_pkg::ADDR_IRQ_CLR, 8'h00);
		wr_reg(aac_pkg::ADDR_MODE, 8'h03);
		n0 = n_start;
		ext_trig <= 1'b1;
		settle(40);
		ext_trig <= 1'b0;
		chk(16'(n_start - n0), 16'h0001);
		chk(irq, 16'h0001);
		rd_reg(aac_pkg::ADDR_STATUS);
		wr_reg(aac_pkg::ADDR_IRQ_CLR, 8'h00);
		wr_reg(aac_pkg::ADDR_MODE, 8'h02);
		n0 = n_start;
		ext_trig <= 1'b1;
		settle(40);
		ext_trig <= 1'b0;
		chk(16'(n_start - n0), 16'h0001);
		chk(irq, 16'h0000);
		$display("test external done");
		// Pacer of 1 x 2 gives one start every 250 cycles
		wr_reg(aac_pkg::ADDR_TMR1_LO, 8'h01);
		wr_reg(aac_pkg::ADDR_TMR2_LO, 8'h02);
		wr_reg(aac_pkg::ADDR_MODE, 8'h04);
		n0 = n_start;
		for (int k = 0; k < 1000 && n_start < n0 + 3; k++) begin
			settle(1);
		end
		chk(16'(gap), 16'd250);
		// Timer with interrupt transfer: next tick must raise the request
		wr_reg(aac_pkg::ADDR_MODE, 8'h05);
		settle(280);
		chk(irq, 16'h0001);
		wr_reg(aac_pkg::ADDR_TMR1_LO, 8'h00);
		settle(20);
		n0 = n_start;
		settle(600);
		chk(16'(n_start - n0), 16'h0000);
		wr_reg(aac_pkg::ADDR_MODE, 8'h00);
		$display("test pacer done");
		tally_and_finish();
	end
endmodule : aac_ctrl_tb_top

// file: rtl/aac_ctrl.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Contract
// - Eight single-ended channels, numbers 0 to 7
// - Channel 0 after reset
// - Five gain codes x1 to x16
// - Gain x1, bipolar after reset
// - Six trigger and transfer modes
// - Reset mode: software trigger, polled
// - Software trigger write starts one conversion
// - Ready bit low when result available
// - No new request until host clears
// - Two cascaded 16-bit pacer dividers
// - Zero divider stops pacer triggers
// - Pacer clocked from 2 MHz source
module aac_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Converter side
	input wire logic ext_trig,
	input wire logic conv_done,
	input wire logic [11:0] conv_data,
	output logic conv_start,
	output logic [2:0] mux_chan,
	output logic [2:0] gain_code,
	output logic bipolar,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		logic [2:0] ext_sync;
		logic ext_last;
		aac_pkg::aac_state_e fsm;
		aac_pkg::aac_conv_s conv;
		aac_pkg::aac_mode_e mode;
		logic [15:0] div1;
		logic [15:0] div2;
		logic [11:0] result;
		logic rdy_n;
		logic irq_req;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] rdata;
		logic irq;
		logic bipolar;
	} aac_state_s;

	aac_state_s st;
	aac_state_s next_st;
	aac_pkg::aac_bus_s bus;
	logic pacer_tick;
	logic ext_edge;
	logic trig;
	logic irq_mode;
	logic [7:0] sts_set;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_addr, input logic strobe);
		hit = strobe && (a == ref_addr);
	endfunction : hit

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	aac_pacer u_pacer (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.run(st.mode == aac_pkg::AAC_MODE_TMR_POLL || st.mode == aac_pkg::AAC_MODE_TMR_IRQ),
		.div1(st.div1),
		.div2(st.div2),
		.tick(pacer_tick)
	);

	// Edge seen only when second and third stages agree on a new level
	assign ext_edge = (st.ext_sync[2] == st.ext_sync[1]) && st.ext_sync[2] && !st.ext_last;
	assign irq_mode = st.mode[0];

	always_comb begin
		case (st.mode)
			aac_pkg::AAC_MODE_SW_POLL, aac_pkg::AAC_MODE_SW_IRQ: trig = hit(bus.addr, aac_pkg::ADDR_SOFT_TRIG, bus.wr);
			aac_pkg::AAC_MODE_EXT_POLL, aac_pkg::AAC_MODE_EXT_IRQ: trig = ext_edge;
			aac_pkg::AAC_MODE_TMR_POLL, aac_pkg::AAC_MODE_TMR_IRQ: trig = pacer_tick;
			default: trig = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.ext_sync = {st.ext_sync[1:0], ext_trig};
		if (st.ext_sync[2] == st.ext_sync[1]) begin
			next_st.ext_last = st.ext_sync[2];
		end
		next_st.conv.start = 1'b0;
		next_st.rdata = 8'h00;
		sts_set = 8'h00;

		// Register writes
		if (hit(bus.addr, aac_pkg::ADDR_CHAN, bus.wr)) begin
			next_st.conv.chan = bus.wdata[2:0];
		end else if (hit(bus.addr, aac_pkg::ADDR_GAIN, bus.wr)) begin
			// Undefined gain codes are ignored so the amplifier never sees one
			if (bus.wdata[2:0] <= aac_pkg::GAIN_X16) begin
				next_st.conv.gain = bus.wdata[2:0];
			end
		end else if (hit(bus.addr, aac_pkg::ADDR_MODE, bus.wr)) begin
			if (bus.wdata[2:0] <= aac_pkg::AAC_MODE_TMR_IRQ) begin
				next_st.mode = aac_pkg::aac_mode_e'(bus.wdata[2:0]);
			end
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR1_LO, bus.wr)) begin
			next_st.div1[7:0] = bus.wdata;
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR1_HI, bus.wr)) begin
			next_st.div1[15:8] = bus.wdata;
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR2_LO, bus.wr)) begin
			next_st.div2[7:0] = bus.wdata;
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR2_HI, bus.wr)) begin
			next_st.div2[15:8] = bus.wdata;
		end else if (hit(bus.addr, aac_pkg::ADDR_IRQ_MASK, bus.wr)) begin
			next_st.mask = bus.wdata;
		end else if (hit(bus.addr, aac_pkg::ADDR_IRQ_CLR, bus.wr)) begin
			next_st.irq_req = 1'b0;
		end

		// Conversion sequencer; triggers while busy are dropped
		case (st.fsm)
			aac_pkg::AAC_IDLE: begin
				if (trig) begin
					next_st.conv.start = 1'b1;
					next_st.rdy_n = 1'b1;
					next_st.fsm = aac_pkg::AAC_START;
				end
			end
			aac_pkg::AAC_START: begin
				next_st.fsm = aac_pkg::AAC_WAIT;
			end
			aac_pkg::AAC_WAIT: begin
				if (conv_done) begin
					next_st.result = conv_data;
					next_st.rdy_n = 1'b0;
					next_st.fsm = aac_pkg::AAC_IDLE;
					sts_set[aac_pkg::CONV_BIT] = 1'b1;
					// One request stands until the host clears it
					if (irq_mode && !st.irq_req) begin
						next_st.irq_req = 1'b1;
						sts_set[aac_pkg::IRQ_BIT] = 1'b1;
					end
				end
			end
			default: next_st.fsm = aac_pkg::AAC_IDLE;
		endcase

		// Sets are kept apart so a status read cannot swallow a new event
		next_st.status = st.status | sts_set;

		// Reads; status read clears sticky bits, but a same-cycle set wins
		if (hit(bus.addr, aac_pkg::ADDR_RES_LO, bus.rd)) begin
			next_st.rdata = st.result[7:0];
		end else if (hit(bus.addr, aac_pkg::ADDR_RES_HI, bus.rd)) begin
			next_st.rdata = {st.rdy_n, 3'h0, st.result[11:8]};
		end else if (hit(bus.addr, aac_pkg::ADDR_STATUS, bus.rd)) begin
			next_st.rdata = st.status;
			next_st.status = sts_set;
		end else if (hit(bus.addr, aac_pkg::ADDR_IRQ_MASK, bus.rd)) begin
			next_st.rdata = st.mask;
		end else if (hit(bus.addr, aac_pkg::ADDR_CHAN, bus.rd)) begin
			next_st.rdata = {5'h00, st.conv.chan};
		end else if (hit(bus.addr, aac_pkg::ADDR_GAIN, bus.rd)) begin
			next_st.rdata = {5'h00, st.conv.gain};
		end else if (hit(bus.addr, aac_pkg::ADDR_MODE, bus.rd)) begin
			next_st.rdata = {5'h00, st.mode};
		end else if (hit(bus.addr, aac_pkg::ADDR_IRQ_STAT, bus.rd)) begin
			next_st.rdata = {st.rdy_n, 6'h00, st.irq_req};
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR1_LO, bus.rd)) begin
			next_st.rdata = st.div1[7:0];
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR1_HI, bus.rd)) begin
			next_st.rdata = st.div1[15:8];
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR2_LO, bus.rd)) begin
			next_st.rdata = st.div2[7:0];
		end else if (hit(bus.addr, aac_pkg::ADDR_TMR2_HI, bus.rd)) begin
			next_st.rdata = st.div2[15:8];
		end

		next_st.irq = |(next_st.status & next_st.mask);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.conv.chan <= aac_pkg::CHAN_RESET;
			st.conv.gain <= aac_pkg::GAIN_X1;
			st.mode <= aac_pkg::aac_mode_e'(aac_pkg::MODE_RESET);
			st.fsm <= aac_pkg::AAC_IDLE;
			st.rdy_n <= 1'b1;
			st.bipolar <= 1'b1;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign conv_start = st.conv.start;
	assign mux_chan = st.conv.chan;
	assign gain_code = st.conv.gain;
	assign bipolar = st.bipolar;
	assign irq = st.irq;

	property p_chan_write;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && wr && addr == aac_pkg::ADDR_CHAN) |=> (mux_chan == $past(wdata[2:0]));
	endproperty
	a_chan_write: assert property (p_chan_write) else $error("channel not taken");

	property p_gain_range;
		@(posedge mclk) disable iff (!reset_n)
		gain_code <= aac_pkg::GAIN_X16;
	endproperty
	a_gain_range: assert property (p_gain_range) else $error("gain code out of range");

	property p_mode_range;
		@(posedge mclk) disable iff (!reset_n)
		st.mode <= aac_pkg::AAC_MODE_TMR_IRQ;
	endproperty
	a_mode_range: assert property (p_mode_range) else $error("mode out of range");

	sequence s_soft_write;
		clk_en && wr && addr == aac_pkg::ADDR_SOFT_TRIG && st.fsm == aac_pkg::AAC_IDLE && st.mode[2:1] == 2'b00;
	endsequence
	property p_soft_trig;
		@(posedge mclk) disable iff (!reset_n)
		s_soft_write |=> conv_start ##1 !conv_start;
	endproperty
	a_soft_trig: assert property (p_soft_trig) else $error("software trigger lost");

	property p_ready;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && st.fsm == aac_pkg::AAC_WAIT && conv_done) |=> (!st.rdy_n && st.result == $past(conv_data));
	endproperty
	a_ready: assert property (p_ready) else $error("ready not shown");

	property p_one_req;
		@(posedge mclk) disable iff (!reset_n)
		(st.irq_req && !(clk_en && wr && addr == aac_pkg::ADDR_IRQ_CLR)) |=> st.irq_req;
	endproperty
	a_one_req: assert property (p_one_req) else $error("request dropped without clear");

	property p_pacer_zero;
		@(posedge mclk) disable iff (!reset_n)
		// Tick is registered, so a divider cleared now stops it one cycle later
		(clk_en && (st.div1 == 16'h0000 || st.div2 == 16'h0000)) |=> !pacer_tick;
	endproperty
	a_pacer_zero: assert property (p_pacer_zero) else $error("pacer ran with zero divider");

	property p_ext_once;
		@(posedge mclk) disable iff (!reset_n)
		ext_edge && clk_en |=> !ext_edge;
	endproperty
	a_ext_once: assert property (p_ext_once) else $error("double external edge");

	property p_poll_noirq;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && !irq_mode && !st.irq_req) |=> !st.irq_req;
	endproperty
	a_poll_noirq: assert property (p_poll_noirq) else $error("request in polled mode");

	sequence s_done;
		clk_en && st.fsm == aac_pkg::AAC_WAIT && conv_done;
	endsequence
	property p_set_wins;
		@(posedge mclk) disable iff (!reset_n)
		s_done |=> st.status[aac_pkg::CONV_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("completion flag lost");

	property p_req_source;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && !st.irq_req && !(st.fsm == aac_pkg::AAC_WAIT && conv_done && irq_mode)) |=> !st.irq_req;
	endproperty
	a_req_source: assert property (p_req_source) else $error("request without completion");

	property p_req_clear;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && st.irq_req && wr && addr == aac_pkg::ADDR_IRQ_CLR) |=> !st.irq_req;
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("request not cleared");

	property p_irq_level;
		@(posedge mclk) disable iff (!reset_n)
		irq == |(st.status & st.mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

	property p_ext_start;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && ext_edge && st.fsm == aac_pkg::AAC_IDLE && st.mode[2:1] == 2'b01) |=> conv_start;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("external edge lost");

	property p_pacer_start;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && pacer_tick && st.fsm == aac_pkg::AAC_IDLE && st.mode[2:1] == 2'b10) |=> conv_start;
	endproperty
	a_pacer_start: assert property (p_pacer_start) else $error("pacer tick lost");

	property p_start_once;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && conv_start) |=> !conv_start;
	endproperty
	a_start_once: assert property (p_start_once) else $error("start longer than one cycle");

	property p_busy_drop;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && st.fsm != aac_pkg::AAC_IDLE) |=> !conv_start;
	endproperty
	a_busy_drop: assert property (p_busy_drop) else $error("start while busy");

	property p_rdata_idle;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && !rd) |=> (rdata == 8'h00);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

	sequence s_read_hi;
		clk_en && rd && addr == aac_pkg::ADDR_RES_HI;
	endsequence
	property p_read_hi;
		@(posedge mclk) disable iff (!reset_n)
		s_read_hi |=> (rdata == {$past(st.rdy_n), 3'h0, $past(st.result[11:8])});
	endproperty
	a_read_hi: assert property (p_read_hi) else $error("high result byte wrong");

	property p_read_lo;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && rd && addr == aac_pkg::ADDR_RES_LO) |=> (rdata == $past(st.result[7:0]));
	endproperty
	a_read_lo: assert property (p_read_lo) else $error("low result byte wrong");

	property p_gain_hold;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && wr && addr == aac_pkg::ADDR_GAIN && wdata[2:0] > aac_pkg::GAIN_X16) |=> $stable(gain_code);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("bad gain code taken");

	property p_mode_hold;
		@(posedge mclk) disable iff (!reset_n)
		(clk_en && wr && addr == aac_pkg::ADDR_MODE && wdata[2:0] > aac_pkg::AAC_MODE_TMR_IRQ) |=> $stable(st.mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("bad mode code taken");
endmodule : aac_ctrl

// file: rtl/aac_pacer.sv
`timescale 1ns/1ps
module aac_pacer (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Control
	input wire logic run,
	input wire logic [15:0] div1,
	input wire logic [15:0] div2,
	// Trigger
	output logic tick
);
	aac_pkg::aac_pacer_s st;
	aac_pkg::aac_pacer_s next_st;
	logic go;

	// A zero in either divider halts pacing
	assign go = run && (div1 != 16'h0000) && (div2 != 16'h0000);

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!go) begin
			next_st.pre = 8'h00;
			next_st.cnt1 = 16'h0000;
			next_st.cnt2 = 16'h0000;
		end else if (st.pre != aac_pkg::PRESCALE_LAST) begin
			next_st.pre = st.pre + 8'h01;
		end else begin
			next_st.pre = 8'h00;
			// Cascade: second stage steps once per first-stage wrap
			if (st.cnt1 >= div1 - 16'h0001) begin
				next_st.cnt1 = 16'h0000;
				if (st.cnt2 >= div2 - 16'h0001) begin
					next_st.cnt2 = 16'h0000;
					next_st.tick = 1'b1;
				end else begin
					next_st.cnt2 = st.cnt2 + 16'h0001;
				end
			end else begin
				next_st.cnt1 = st.cnt1 + 16'h0001;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule : aac_pacer

// file: rtl/aac_pkg.sv
package aac_pkg;
	// Register offsets
	localparam logic [3:0] ADDR_TMR1_LO = 4'h0;
	localparam logic [3:0] ADDR_TMR1_HI = 4'h1;
	localparam logic [3:0] ADDR_TMR2_LO = 4'h2;
	localparam logic [3:0] ADDR_TMR2_HI = 4'h3;
	localparam logic [3:0] ADDR_RES_LO = 4'h4;
	localparam logic [3:0] ADDR_RES_HI = 4'h5;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
	localparam logic [3:0] ADDR_STATUS = 4'h7;
	localparam logic [3:0] ADDR_CHAN = 4'h8;
	localparam logic [3:0] ADDR_GAIN = 4'h9;
	localparam logic [3:0] ADDR_MODE = 4'hA;
	localparam logic [3:0] ADDR_IRQ_CLR = 4'hB;
	localparam logic [3:0] ADDR_SOFT_TRIG = 4'hC;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'hD;

	// Field layouts and reset values
	localparam logic [2:0] CHAN_RESET = 3'h0;
	localparam logic [2:0] GAIN_X1 = 3'h0;
	localparam logic [2:0] GAIN_X2 = 3'h1;
	localparam logic [2:0] GAIN_X4 = 3'h2;
	localparam logic [2:0] GAIN_X8 = 3'h3;
	localparam logic [2:0] GAIN_X16 = 3'h4;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam int RES_W = 12;
	localparam int DIV_W = 16;
	localparam int RDY_BIT = 4;
	localparam int IRQ_BIT = 0;
	localparam int CONV_BIT = 1;

	// Timing: pacer source 2 MHz from a 250 MHz clock
	localparam int CLK_MHZ = 250;
	localparam int PACER_MHZ = 2;
	localparam int PACER_PRESCALE = CLK_MHZ / PACER_MHZ;
	localparam logic [7:0] PRESCALE_LAST = 8'(PACER_PRESCALE - 1);

	typedef enum logic [2:0] {
		AAC_MODE_SW_POLL = 3'b000,
		AAC_MODE_SW_IRQ = 3'b001,
		AAC_MODE_EXT_POLL = 3'b010,
		AAC_MODE_EXT_IRQ = 3'b011,
		AAC_MODE_TMR_POLL = 3'b100,
		AAC_MODE_TMR_IRQ = 3'b101
	} aac_mode_e;

	typedef enum logic [1:0] {
		AAC_IDLE = 2'b00,
		AAC_START = 2'b01,
		AAC_WAIT = 2'b10
	} aac_state_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} aac_bus_s;

	typedef struct packed {
		logic start;
		logic [2:0] chan;
		logic [2:0] gain;
	} aac_conv_s;

	typedef struct packed {
		logic [7:0] pre;
		logic [15:0] cnt1;
		logic [15:0] cnt2;
		logic tick;
	} aac_pacer_s;
endpackage : aac_pkg
